// File: psalu_top.v
// Packed integer SIMD execution datapath
`timescale 1ns/10ps
`include "psalu_defs.vh"

// Functional notes
// - Exactly 47 opcodes, others flagged illegal
// - Ops accepted only when feature bit 23 set
// - Doubleword move copies low 32 bits
// - Quadword move copies all 64 bits
// - Wraparound add/sub drops element carries
// - Signed saturating add/sub clamps signed range
// - Unsigned saturating add/sub clamps unsigned range
// - Word multiply keeps high or low half
// - Multiply-add sums product pairs into dwords
// - Compare equal or signed greater per element
// - Compare writes all-ones or all-zeros element
// - Compares leave arithmetic flags untouched
// - Signed pack narrows with signed saturation
// - Unsigned pack narrows signed words, unsigned saturation
// - Unpack interleaves high or low halves
// - Bitwise AND, AND-NOT, OR, XOR on quadword
// - Shifts apply count to each element
// - Logical shifts fill vacated bits with zeros
// - Arithmetic right shifts replicate sign bit
// - Empty-state op sets all tags empty
// - Saturation limits 7f/80, 7fff/8000, ff/00, ffff/0000
// - Other ops set all tags valid
// - Other ops clear stack-top field
module psalu_top #(
	parameter FEATURE_PRESENT = 1
) (
	// Clock and reset
	input  wire                            sys_clk_i,
	input  wire                            resetn_i,
	// Instruction request
	input  wire                            op_valid_i,
	input  wire [`PSALU_OPC_W-1:0]         opcode_i,
	input  wire [`PSALU_REG_AW-1:0]        dst_idx_i,
	input  wire [`PSALU_REG_AW-1:0]        src_idx_i,
	input  wire                            src_ext_i,
	input  wire                            dst_ext_i,
	input  wire [`PSALU_DATA_W-1:0]        ext_data_i,
	output reg                             ready_o,
	// Result
	output reg                             done_o,
	output reg                             illegal_o,
	output reg                             result_ext_o,
	output reg  [`PSALU_DATA_W-1:0]        result_o,
	// Aliased floating-point state
	output reg  [`PSALU_TAG_W-1:0]         tag_word_o,
	output reg  [`PSALU_STACK_TOP_W-1:0]   stack_top_o,
	// Feature word
	output reg  [31:0]                     feature_word_o
);

////////////////////////////////////////////////////////////////////////////////
// Saturation helpers
function [7:0] ssat8;
	input [15:0] v;
	begin
		if (!v[15] && |v[14:7])
			ssat8 = 8'h7f;
		else if (v[15] && !(&v[14:7]))
			ssat8 = 8'h80;
		else
			ssat8 = v[7:0];
	end
endfunction

function [15:0] ssat16;
	input [31:0] v;
	begin
		if (!v[31] && |v[30:15])
			ssat16 = 16'h7fff;
		else if (v[31] && !(&v[30:15]))
			ssat16 = 16'h8000;
		else
			ssat16 = v[15:0];
	end
endfunction

function [7:0] usat8;
	input [15:0] v;
	begin
		if (v[15])
			usat8 = 8'h00;
		else if (|v[14:8])
			usat8 = 8'hff;
		else
			usat8 = v[7:0];
	end
endfunction

function [15:0] usat16;
	input [31:0] v;
	begin
		if (v[31])
			usat16 = 16'h0000;
		else if (|v[30:16])
			usat16 = 16'hffff;
		else
			usat16 = v[15:0];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Issue stage
reg                         busy;
reg [`PSALU_OPC_W-1:0]      op_q;
reg [`PSALU_REG_AW-1:0]     dst_q;
reg                         src_ext_q;
reg                         dst_ext_q;
reg [`PSALU_DATA_W-1:0]     ext_q;
wire [`PSALU_DATA_W-1:0]    rd_d;
wire [`PSALU_DATA_W-1:0]    rd_s;
wire                        op_known = (opcode_i <= `PSALU_OP_LAST);
wire                        take = op_valid_i && ready_o;
wire                        accept = take && op_known && feature_word_o[`PSALU_FEATURE_BIT];

always @(posedge sys_clk_i) begin
	if (!resetn_i) begin
		busy           <= 1'b0;
		ready_o        <= 1'b0;
		illegal_o      <= 1'b0;
		op_q           <= `PSALU_OP_EMPTY_PACKED_STATE;
		dst_q          <= {`PSALU_REG_AW{1'b0}};
		src_ext_q      <= 1'b0;
		dst_ext_q      <= 1'b0;
		ext_q          <= {`PSALU_DATA_W{1'b0}};
		feature_word_o <= 32'h0000_0000;
	end else begin
		feature_word_o[`PSALU_FEATURE_BIT] <= (FEATURE_PRESENT != 0);
		busy      <= accept;
		ready_o   <= !accept;
		illegal_o <= take && !accept;
		if (accept) begin
			op_q      <= opcode_i;
			dst_q     <= dst_idx_i;
			src_ext_q <= src_ext_i;
			dst_ext_q <= dst_ext_i;
			ext_q     <= ext_data_i;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register file
wire wr_en = busy && !dst_ext_q && (op_q != `PSALU_OP_EMPTY_PACKED_STATE);
reg  [`PSALU_DATA_W-1:0] next_result;

psalu_regfile #(
	.W     (`PSALU_DATA_W),
	.DEPTH (`PSALU_REG_CNT),
	.AW    (`PSALU_REG_AW)
) u_regfile (
	.sys_clk_i   (sys_clk_i),
	.resetn_i    (resetn_i),
	.rd_a_addr_i (dst_idx_i),
	.rd_b_addr_i (src_idx_i),
	.rd_a_data_o (rd_d),
	.rd_b_data_o (rd_s),
	.wr_en_i     (wr_en),
	.wr_addr_i   (dst_q),
	.wr_data_i   (next_result)
);

wire [63:0] d = rd_d;
wire [63:0] s = src_ext_q ? ext_q : rd_s;
wire        big_w = |s[63:4];
wire        big_d = |s[63:5];
wire        big_q = |s[63:6];

////////////////////////////////////////////////////////////////////////////////
// Byte lanes
wire [63:0] add_b, sub_b, adds_b, subs_b, addu_b, subu_b, ceq_b, cgt_b;
wire [63:0] pks_b, pku_b, ilh_b, ill_b;
genvar i;
generate
	for (i = 0; i < 8; i = i + 1) begin : g_byte
		wire [7:0]  a  = d[8*i+:8];
		wire [7:0]  b  = s[8*i+:8];
		wire [15:0] sa = {{8{a[7]}}, a};
		wire [15:0] sb = {{8{b[7]}}, b};
		wire [15:0] ua = {8'h00, a};
		wire [15:0] ub = {8'h00, b};
		wire [15:0] nw = (i < 4) ? d[16*(i%4)+:16] : s[16*(i%4)+:16];
		assign add_b[8*i+:8]  = a + b;
		assign sub_b[8*i+:8]  = a - b;
		assign adds_b[8*i+:8] = ssat8(sa + sb);
		assign subs_b[8*i+:8] = ssat8(sa - sb);
		assign addu_b[8*i+:8] = usat8(ua + ub);
		assign subu_b[8*i+:8] = usat8(ua - ub);
		assign ceq_b[8*i+:8]  = {8{a == b}};
		assign cgt_b[8*i+:8]  = {8{$signed(a) > $signed(b)}};
		assign pks_b[8*i+:8]  = ssat8(nw);
		assign pku_b[8*i+:8]  = usat8(nw);
	end
	for (i = 0; i < 4; i = i + 1) begin : g_ilv_b
		assign ill_b[16*i+:16] = {s[8*i+:8], d[8*i+:8]};
		assign ilh_b[16*i+:16] = {s[8*(i+4)+:8], d[8*(i+4)+:8]};
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Word lanes
wire [63:0] add_w, sub_w, adds_w, subs_w, addu_w, subu_w, ceq_w, cgt_w;
wire [63:0] mulh_w, mull_w, pks_w, sll_w, srl_w, sra_w, ilh_w, ill_w;
generate
	for (i = 0; i < 4; i = i + 1) begin : g_word
		wire [15:0]        a  = d[16*i+:16];
		wire [15:0]        b  = s[16*i+:16];
		wire [31:0]        sa = {{16{a[15]}}, a};
		wire [31:0]        sb = {{16{b[15]}}, b};
		wire [31:0]        ua = {16'h0000, a};
		wire [31:0]        ub = {16'h0000, b};
		wire signed [31:0] p  = $signed(a) * $signed(b);
		wire [31:0]        nd = (i < 2) ? d[32*(i%2)+:32] : s[32*(i%2)+:32];
		wire [3:0]         sc = big_w ? 4'hf : s[3:0];
		assign add_w[16*i+:16]  = a + b;
		assign sub_w[16*i+:16]  = a - b;
		assign adds_w[16*i+:16] = ssat16(sa + sb);
		assign subs_w[16*i+:16] = ssat16(sa - sb);
		assign addu_w[16*i+:16] = usat16(ua + ub);
		assign subu_w[16*i+:16] = usat16(ua - ub);
		assign ceq_w[16*i+:16]  = {16{a == b}};
		assign cgt_w[16*i+:16]  = {16{$signed(a) > $signed(b)}};
		assign mulh_w[16*i+:16] = p[31:16];
		assign mull_w[16*i+:16] = p[15:0];
		assign pks_w[16*i+:16]  = ssat16(nd);
		assign sll_w[16*i+:16]  = big_w ? 16'h0000 : (a << s[3:0]);
		assign srl_w[16*i+:16]  = big_w ? 16'h0000 : (a >> s[3:0]);
		assign sra_w[16*i+:16]  = $signed(a) >>> sc;
	end
	for (i = 0; i < 2; i = i + 1) begin : g_ilv_w
		assign ill_w[32*i+:32] = {s[16*i+:16], d[16*i+:16]};
		assign ilh_w[32*i+:32] = {s[16*(i+2)+:16], d[16*(i+2)+:16]};
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Doubleword lanes
wire [63:0] add_d, sub_d, ceq_d, cgt_d, madd_d, sll_d, srl_d, sra_d;
generate
	for (i = 0; i < 2; i = i + 1) begin : g_dword
		wire [31:0] a  = d[32*i+:32];
		wire [31:0] b  = s[32*i+:32];
		wire [4:0]  sc = big_d ? 5'h1f : s[4:0];
		assign add_d[32*i+:32]  = a + b;
		assign sub_d[32*i+:32]  = a - b;
		assign ceq_d[32*i+:32]  = {32{a == b}};
		assign cgt_d[32*i+:32]  = {32{$signed(a) > $signed(b)}};
		assign madd_d[32*i+:32] = g_word[2*i].p + g_word[2*i+1].p;
		assign sll_d[32*i+:32]  = big_d ? 32'h0000_0000 : (a << s[4:0]);
		assign srl_d[32*i+:32]  = big_d ? 32'h0000_0000 : (a >> s[4:0]);
		assign sra_d[32*i+:32]  = $signed(a) >>> sc;
	end
endgenerate

wire [63:0] sll_q = big_q ? 64'h0 : (d << s[5:0]);
wire [63:0] srl_q = big_q ? 64'h0 : (d >> s[5:0]);

////////////////////////////////////////////////////////////////////////////////
// Result select, no flag outputs exist so compares cannot touch flags
always @* begin
	case (op_q)
		`PSALU_OP_MOVE_DOUBLEWORD:           next_result = {32'h0000_0000, s[31:0]};
		`PSALU_OP_MOVE_QUADWORD:             next_result = s;
		`PSALU_OP_PACKED_ADD_BYTE_WRAP:      next_result = add_b;
		`PSALU_OP_PACKED_ADD_WORD_WRAP:      next_result = add_w;
		`PSALU_OP_PACKED_ADD_DWORD_WRAP:     next_result = add_d;
		`PSALU_OP_PACKED_SUB_BYTE_WRAP:      next_result = sub_b;
		`PSALU_OP_PACKED_SUB_WORD_WRAP:      next_result = sub_w;
		`PSALU_OP_PACKED_SUB_DWORD_WRAP:     next_result = sub_d;
		`PSALU_OP_PACKED_ADD_BYTE_SSAT:      next_result = adds_b;
		`PSALU_OP_PACKED_ADD_WORD_SSAT:      next_result = adds_w;
		`PSALU_OP_PACKED_SUB_BYTE_SSAT:      next_result = subs_b;
		`PSALU_OP_PACKED_SUB_WORD_SSAT:      next_result = subs_w;
		`PSALU_OP_PACKED_ADD_BYTE_USAT:      next_result = addu_b;
		`PSALU_OP_PACKED_ADD_WORD_USAT:      next_result = addu_w;
		`PSALU_OP_PACKED_SUB_BYTE_USAT:      next_result = subu_b;
		`PSALU_OP_PACKED_SUB_WORD_USAT:      next_result = subu_w;
		`PSALU_OP_WORD_MULTIPLY_HIGH:        next_result = mulh_w;
		`PSALU_OP_WORD_MULTIPLY_LOW:         next_result = mull_w;
		`PSALU_OP_WORD_MULTIPLY_PAIR_SUM:    next_result = madd_d;
		`PSALU_OP_COMPARE_EQUAL_BYTE:        next_result = ceq_b;
		`PSALU_OP_COMPARE_EQUAL_WORD:        next_result = ceq_w;
		`PSALU_OP_COMPARE_EQUAL_DWORD:       next_result = ceq_d;
		`PSALU_OP_COMPARE_GREATER_BYTE:      next_result = cgt_b;
		`PSALU_OP_COMPARE_GREATER_WORD:      next_result = cgt_w;
		`PSALU_OP_COMPARE_GREATER_DWORD:     next_result = cgt_d;
		`PSALU_OP_NARROW_WORD_TO_BYTE_SSAT:  next_result = pks_b;
		`PSALU_OP_NARROW_DWORD_TO_WORD_SSAT: next_result = pks_w;
		`PSALU_OP_NARROW_WORD_TO_BYTE_USAT:  next_result = pku_b;
		`PSALU_OP_INTERLEAVE_HIGH_BYTES:     next_result = ilh_b;
		`PSALU_OP_INTERLEAVE_HIGH_WORDS:     next_result = ilh_w;
		`PSALU_OP_INTERLEAVE_HIGH_DWORDS:    next_result = {s[63:32], d[63:32]};
		`PSALU_OP_INTERLEAVE_LOW_BYTES:      next_result = ill_b;
		`PSALU_OP_INTERLEAVE_LOW_WORDS:      next_result = ill_w;
		`PSALU_OP_INTERLEAVE_LOW_DWORDS:     next_result = {s[31:0], d[31:0]};
		`PSALU_OP_QUAD_BITWISE_AND:          next_result = d & s;
		`PSALU_OP_QUAD_BITWISE_AND_NOT:      next_result = ~d & s;
		`PSALU_OP_QUAD_BITWISE_OR:           next_result = d | s;
		`PSALU_OP_QUAD_BITWISE_XOR:          next_result = d ^ s;
		`PSALU_OP_SHIFT_LEFT_LOGICAL_WORD:   next_result = sll_w;
		`PSALU_OP_SHIFT_LEFT_LOGICAL_DWORD:  next_result = sll_d;
		`PSALU_OP_SHIFT_LEFT_LOGICAL_QUAD:   next_result = sll_q;
		`PSALU_OP_SHIFT_RIGHT_LOGICAL_WORD:  next_result = srl_w;
		`PSALU_OP_SHIFT_RIGHT_LOGICAL_DWORD: next_result = srl_d;
		`PSALU_OP_SHIFT_RIGHT_LOGICAL_QUAD:  next_result = srl_q;
		`PSALU_OP_SHIFT_RIGHT_ARITH_WORD:    next_result = sra_w;
		`PSALU_OP_SHIFT_RIGHT_ARITH_DWORD:   next_result = sra_d;
		default:                             next_result = 64'h0000_0000_0000_0000;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Completion and aliased floating-point state
always @(posedge sys_clk_i) begin
	if (!resetn_i) begin
		done_o       <= 1'b0;
		result_ext_o <= 1'b0;
		result_o     <= 64'h0000_0000_0000_0000;
		tag_word_o   <= `PSALU_TAG_ALL_EMPTY;
		stack_top_o  <= `PSALU_STACK_TOP_ZERO;
	end else begin
		done_o <= busy;
		if (busy) begin
			result_o     <= next_result;
			result_ext_o <= dst_ext_q;
			if (op_q == `PSALU_OP_EMPTY_PACKED_STATE) begin
				tag_word_o <= `PSALU_TAG_ALL_EMPTY;
			end else begin
				tag_word_o  <= `PSALU_TAG_ALL_VALID;
				stack_top_o <= `PSALU_STACK_TOP_ZERO;
			end
		end
	end
end

endmodule

// File: psalu_defs.vh
// Constants for the packed integer SIMD datapath
`ifndef PSALU_DEFS_VH
`define PSALU_DEFS_VH

// Operand geometry
`define PSALU_DATA_W                          64
`define PSALU_OPC_W                           6
`define PSALU_REG_CNT                         8
`define PSALU_REG_AW                          3

// Feature word
`define PSALU_FEATURE_BIT                     23

// Tag word and stack top values
`define PSALU_TAG_W                           16
`define PSALU_TAG_ALL_VALID                   16'h0000
`define PSALU_TAG_ALL_EMPTY                   16'hffff
`define PSALU_STACK_TOP_W                     3
`define PSALU_STACK_TOP_ZERO                  3'h0

// Opcodes, 47 in all
`define PSALU_OP_MOVE_DOUBLEWORD              6'h00
`define PSALU_OP_MOVE_QUADWORD                6'h01
`define PSALU_OP_PACKED_ADD_BYTE_WRAP         6'h02
`define PSALU_OP_PACKED_ADD_WORD_WRAP         6'h03
`define PSALU_OP_PACKED_ADD_DWORD_WRAP        6'h04
`define PSALU_OP_PACKED_SUB_BYTE_WRAP         6'h05
`define PSALU_OP_PACKED_SUB_WORD_WRAP         6'h06
`define PSALU_OP_PACKED_SUB_DWORD_WRAP        6'h07
`define PSALU_OP_PACKED_ADD_BYTE_SSAT         6'h08
`define PSALU_OP_PACKED_ADD_WORD_SSAT         6'h09
`define PSALU_OP_PACKED_SUB_BYTE_SSAT         6'h0a
`define PSALU_OP_PACKED_SUB_WORD_SSAT         6'h0b
`define PSALU_OP_PACKED_ADD_BYTE_USAT         6'h0c
`define PSALU_OP_PACKED_ADD_WORD_USAT         6'h0d
`define PSALU_OP_PACKED_SUB_BYTE_USAT         6'h0e
`define PSALU_OP_PACKED_SUB_WORD_USAT         6'h0f
`define PSALU_OP_WORD_MULTIPLY_HIGH           6'h10
`define PSALU_OP_WORD_MULTIPLY_LOW            6'h11
`define PSALU_OP_WORD_MULTIPLY_PAIR_SUM       6'h12
`define PSALU_OP_COMPARE_EQUAL_BYTE           6'h13
`define PSALU_OP_COMPARE_EQUAL_WORD           6'h14
`define PSALU_OP_COMPARE_EQUAL_DWORD          6'h15
`define PSALU_OP_COMPARE_GREATER_BYTE         6'h16
`define PSALU_OP_COMPARE_GREATER_WORD         6'h17
`define PSALU_OP_COMPARE_GREATER_DWORD        6'h18
`define PSALU_OP_NARROW_WORD_TO_BYTE_SSAT     6'h19
`define PSALU_OP_NARROW_DWORD_TO_WORD_SSAT    6'h1a
`define PSALU_OP_NARROW_WORD_TO_BYTE_USAT     6'h1b
`define PSALU_OP_INTERLEAVE_HIGH_BYTES        6'h1c
`define PSALU_OP_INTERLEAVE_HIGH_WORDS        6'h1d
`define PSALU_OP_INTERLEAVE_HIGH_DWORDS       6'h1e
`define PSALU_OP_INTERLEAVE_LOW_BYTES         6'h1f
`define PSALU_OP_INTERLEAVE_LOW_WORDS         6'h20
`define PSALU_OP_INTERLEAVE_LOW_DWORDS        6'h21
`define PSALU_OP_QUAD_BITWISE_AND             6'h22
`define PSALU_OP_QUAD_BITWISE_AND_NOT         6'h23
`define PSALU_OP_QUAD_BITWISE_OR              6'h24
`define PSALU_OP_QUAD_BITWISE_XOR             6'h25
`define PSALU_OP_SHIFT_LEFT_LOGICAL_WORD      6'h26
`define PSALU_OP_SHIFT_LEFT_LOGICAL_DWORD     6'h27
`define PSALU_OP_SHIFT_LEFT_LOGICAL_QUAD      6'h28
`define PSALU_OP_SHIFT_RIGHT_LOGICAL_WORD     6'h29
`define PSALU_OP_SHIFT_RIGHT_LOGICAL_DWORD    6'h2a
`define PSALU_OP_SHIFT_RIGHT_LOGICAL_QUAD     6'h2b
`define PSALU_OP_SHIFT_RIGHT_ARITH_WORD       6'h2c
`define PSALU_OP_SHIFT_RIGHT_ARITH_DWORD      6'h2d
`define PSALU_OP_EMPTY_PACKED_STATE           6'h2e
`define PSALU_OP_LAST                         6'h2e

`endif

// File: psalu_regfile.v
// Packed register file with registered read ports
`timescale 1ns/10ps
module psalu_regfile #(
	parameter W     = 64,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire          sys_clk_i,
	input  wire          resetn_i,
	// Read ports
	input  wire [AW-1:0] rd_a_addr_i,
	input  wire [AW-1:0] rd_b_addr_i,
	output reg  [W-1:0]  rd_a_data_o,
	output reg  [W-1:0]  rd_b_data_o,
	// Write port
	input  wire          wr_en_i,
	input  wire [AW-1:0] wr_addr_i,
	input  wire [W-1:0]  wr_data_i
);

reg [W-1:0] mem [0:DEPTH-1];

////////////////////////////////////////////////////////////////////////////////
// Storage, read returns old data on same-edge write
always @(posedge sys_clk_i) begin
	if (wr_en_i) begin
		mem[wr_addr_i] <= wr_data_i;
	end
end

always @(posedge sys_clk_i) begin
	if (!resetn_i) begin
		rd_a_data_o <= {W{1'b0}};
		rd_b_data_o <= {W{1'b0}};
	end else begin
		rd_a_data_o <= mem[rd_a_addr_i];
		rd_b_data_o <= mem[rd_b_addr_i];
	end
end

endmodule

// File: psalu_top_asserts.sv
// Port assertions for the packed integer datapath
`timescale 1ns/10ps
`include "psalu_defs.vh"
module psalu_top_asserts #(
	parameter FEATURE_PRESENT = 1
) (
	// Clock and reset
	input wire logic                      sys_clk_i,
	input wire logic                      resetn_i,
	// Request
	input wire logic                      op_valid_i,
	input wire logic [`PSALU_OPC_W-1:0]   opcode_i,
	input wire logic                      dst_ext_i,
	input wire logic                      ready_o,
	// Result and state
	input wire logic                      done_o,
	input wire logic                      illegal_o,
	input wire logic                      result_ext_o,
	input wire logic [`PSALU_DATA_W-1:0]  result_o,
	input wire logic [`PSALU_TAG_W-1:0]   tag_word_o,
	input wire logic [2:0]                stack_top_o,
	input wire logic [31:0]               feature_word_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	reg [`PSALU_OPC_W-1:0] last_op;
	reg                    last_ext;

	// Opcode and direction of the last taken request
	always @(posedge sys_clk_i) begin
		if (op_valid_i && ready_o) begin
			last_op  <= opcode_i;
			last_ext <= dst_ext_i;
		end
	end

	////////////////////////////////////////////////////////////////
	sequence s_take_ok;
		op_valid_i && ready_o && opcode_i <= `PSALU_OP_LAST && FEATURE_PRESENT != 0;
	endsequence
	sequence s_take_bad;
		op_valid_i && ready_o && (opcode_i > `PSALU_OP_LAST || FEATURE_PRESENT == 0);
	endsequence
	sequence s_answer;
		!ready_o && !done_o ##1 ready_o && done_o && !illegal_o;
	endsequence

	answer_timing_a: assert property (s_take_ok |=> s_answer)
		else $error("accepted request not answered two cycles later");
	refuse_code_a: assert property (s_take_bad |=> illegal_o && !done_o ##1 !done_o)
		else $error("refused request not flagged");
	busy_ignore_a: assert property (op_valid_i && !ready_o |=> !illegal_o)
		else $error("request while busy was taken");
	tag_valid_a: assert property (done_o && last_op != `PSALU_OP_EMPTY_PACKED_STATE |-> tag_word_o == `PSALU_TAG_ALL_VALID)
		else $error("tag word not valid after packed op");
	stack_clear_a: assert property (done_o && last_op != `PSALU_OP_EMPTY_PACKED_STATE |-> stack_top_o == 3'h0)
		else $error("stack top not cleared");
	tag_empty_a: assert property (done_o && last_op == `PSALU_OP_EMPTY_PACKED_STATE |-> tag_word_o == `PSALU_TAG_ALL_EMPTY)
		else $error("tag word not empty after empty-state op");
	result_hold_a: assert property (!done_o |-> $stable(result_o) && $stable(tag_word_o))
		else $error("result or tag changed without completion");
	ext_copy_a: assert property (done_o |-> result_ext_o == last_ext)
		else $error("result direction does not match request");
	feature_bit_a: assert property (ready_o |-> feature_word_o == (FEATURE_PRESENT != 0 ? 32'h0080_0000 : 32'h0))
		else $error("feature word wrong");
endmodule

// File: psalu_host.sv
// Decoder and operand source model that issues requests
`timescale 1ns/10ps
module psalu_host (
	// Clock and handshake
	input  wire logic        sys_clk_i,
	input  wire logic        ready_i,
	input  wire logic        done_i,
	input  wire logic        illegal_i,
	// Request
	output logic             op_valid_o,
	output logic [5:0]       opcode_o,
	output logic [2:0]       dst_idx_o,
	output logic [2:0]       src_idx_o,
	output logic             src_ext_o,
	output logic             dst_ext_o,
	output logic [63:0]      ext_data_o
);
	initial begin
		op_valid_o = 0;
		opcode_o = 0;
		dst_idx_o = 0;
		src_idx_o = 0;
		src_ext_o = 0;
		dst_ext_o = 0;
		ext_data_o = 0;
	end

	// One request at a falling edge once ready, optional poke while busy
	task automatic issue(input [5:0] op, input [2:0] di, si, input sx, dx, input [63:0] v,
			input poke, output gd, gi);
		integer k;
		k = 0;
		@(negedge sys_clk_i);
		while (ready_i !== 1'b1 && k < 8) begin
			@(negedge sys_clk_i);
			k = k + 1;
		end
		op_valid_o = 1;
		opcode_o = op;
		dst_idx_o = di;
		src_idx_o = si;
		src_ext_o = sx;
		dst_ext_o = dx;
		ext_data_o = v;
		@(negedge sys_clk_i);
		op_valid_o = poke;
		if (poke) opcode_o = 6'h3f;
		for (k = 0; k < 4 && done_i !== 1'b1 && illegal_i !== 1'b1; k = k + 1) begin
			@(negedge sys_clk_i);
			op_valid_o = 0;
		end
		gd = done_i;
		gi = illegal_i;
	endtask
endmodule

// File: psalu_top_test.sv
// Self-checking bench for the packed integer datapath
`timescale 1ns/10ps
`include "psalu_defs.vh"
module psalu_top_test;
	reg          sys_clk_i, resetn_i, gd, gi;
	wire         op_valid, src_ext, dst_ext, ready, done, illegal, res_ext;
	wire [5:0]   opcode;
	wire [2:0]   dst_idx, src_idx, stack_top;
	wire [63:0]  ext_data, result;
	wire [15:0]  tag_word;
	wire [31:0]  feature_word, feature_nf;
	wire [1:0]   nf_out;
	reg          nf_take;
	integer      err_count, tests_run, cycles, op, it, seed;
	reg  [63:0]  d, s;
	reg  [2:0]   r;

	psalu_top #(.FEATURE_PRESENT(1)) dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.op_valid_i(op_valid), .opcode_i(opcode), .dst_idx_i(dst_idx), .src_idx_i(src_idx),
		.src_ext_i(src_ext), .dst_ext_i(dst_ext), .ext_data_i(ext_data), .ready_o(ready),
		.done_o(done), .illegal_o(illegal), .result_ext_o(res_ext), .result_o(result),
		.tag_word_o(tag_word), .stack_top_o(stack_top), .feature_word_o(feature_word));
	psalu_host host (.sys_clk_i(sys_clk_i), .ready_i(ready), .done_i(done),
		.illegal_i(illegal), .op_valid_o(op_valid), .opcode_o(opcode), .dst_idx_o(dst_idx),
		.src_idx_o(src_idx), .src_ext_o(src_ext), .dst_ext_o(dst_ext), .ext_data_o(ext_data));
	psalu_top #(.FEATURE_PRESENT(0)) dut_nf (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.op_valid_i(op_valid), .opcode_i(opcode), .dst_idx_i(dst_idx), .src_idx_i(src_idx),
		.src_ext_i(src_ext), .dst_ext_i(dst_ext), .ext_data_i(ext_data), .ready_o(),
		.done_o(nf_out[1]), .illegal_o(nf_out[0]), .result_ext_o(), .result_o(),
		.tag_word_o(), .stack_top_o(), .feature_word_o(feature_nf));

	////////////////////////////////////////////////////////////////
	function automatic [63:0] gv(input [63:0] v, input integer w, i, input sg);
		reg [63:0] m;
		m = (w == 64) ? ~64'h0 : (64'h1 << w) - 1;
		gv = (v >> (w * i)) & m;
		if (sg && gv[w-1]) gv = gv | ~m;
	endfunction

	function automatic [63:0] model(input integer k, input [63:0] d, s);
		integer w, i, md;
		reg signed [63:0] a, b, x, lo, hi;
		model = 0;
		md = 0;
		w = 16 << ((k - 38) % 3);
		if (k < 8) w = 8 << ((k - 2) % 3);
		else if (k < 16) begin
			w = 8 << (k % 2);
			md = k < 12 ? 1 : 2;
		end
		else if (k < 19) w = k == 18 ? 32 : 16;
		else if (k < 25) w = 8 << ((k - 19) % 3);
		else if (k < 28) begin
			w = k == 26 ? 16 : 8;
			md = k == 27 ? 2 : 1;
		end
		else if (k < 34) w = 8 << ((k - 28) % 3);
		if (k == 0) model = {32'h0, s[31:0]};
		else if (k == 1) model = s;
		else if (k >= 34 && k <= 37)
			model = k == 34 ? d & s : k == 35 ? ~d & s : k == 36 ? d | s : d ^ s;
		else if (k != 46) for (i = 0; i < 64 / w; i = i + 1) begin
			a = gv(d, w, i, k < 38 ? md != 2 : k >= 44);
			b = gv(s, w, i, md != 2);
			if (k < 16) x = (k < 8 ? k >= 5 : k % 4 >= 2) ? a - b : a + b;
			else if (k < 18) x = k == 16 ? (a * b) >>> 16 : a * b;
			else if (k == 18)
				x = gv(d, 16, 2*i, 1) * gv(s, 16, 2*i, 1) + gv(d, 16, 2*i+1, 1) * gv(s, 16, 2*i+1, 1);
			else if (k < 25) x = (k < 22 ? a == b : a > b) ? -1 : 0;
			else if (k < 28) x = i < 32 / w ? gv(d, 2*w, i, 1) : gv(s, 2*w, i - 32/w, 1);
			else if (k < 34) x = gv(i % 2 ? s : d, w, i / 2 + (k < 31 ? 32 / w : 0), 0);
			else if (k >= 44) x = a >>> (s >= w ? w - 1 : s);
			else x = s >= w ? 0 : k < 41 ? a << s : a >> s;
			lo = md == 1 ? -(64'sd1 << (w - 1)) : 0;
			hi = md == 1 ? (64'sd1 << (w - 1)) - 1 : (64'sd1 << w) - 1;
			if (md != 0 && x < lo) x = lo;
			if (md != 0 && x > hi) x = hi;
			model = model | (gv(x, w, 0, 0) << (w * i));
		end
	endfunction

	task chk(input string nm, input [63:0] e, g);
		tests_run = tests_run + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			test_done;
		end
	end

	// Instance without the feature refuses every request it takes
	always @(posedge sys_clk_i) nf_take <= resetn_i && op_valid;
	always @(negedge sys_clk_i)
		if (nf_take === 1'b1) chk("feature gate", 64'h1, {62'h0, nf_out});

	initial begin
		err_count = 0;
		tests_run = 0;
		cycles = 0;
		seed = 32'hf1e554f2;
		resetn_i = 0;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i) resetn_i = 1;
		@(negedge sys_clk_i);
		chk("feature", 64'h0080_0000, {32'h0, feature_word});
		chk("feature off", 64'h0, {32'h0, feature_nf});
		for (op = 0; op <= `PSALU_OP_LAST; op = op + 1)
			for (it = 0; it < 6; it = it + 1) begin
				r = 3'($random(seed));
				d = it == 0 ? 64'h7fff_8000_7f80_ff00 : {$random(seed), $random(seed)};
				s = it == 0 ? 64'h0001_ffff_0180_0101 : {$random(seed), $random(seed)};
				if (it == 1) d = 64'h8000_7fff_0080_00ff;
				if (it == 1) s = 64'h7fff_8000_ff80_ff01;
				if (op >= 38 && op <= 45)
					s = it == 0 ? 15 : it == 1 ? 16 : it == 2 ? 32 : it == 3 ? 63 : it == 4 ? 64 : {$random(seed)} % 70;
				host.issue(`PSALU_OP_MOVE_QUADWORD, r, 3'h0, 1, 0, d, 0, gd, gi);
				host.issue(op[5:0], r, 3'h0, 1, 1, s, it == 2, gd, gi);
				chk("done", 1, gd);
				if (op < 16) chk("result", model(op, d, s), result);
				else if (op < 25) chk("result", model(op, d, s), result);
				else if (op < 38) chk("result", model(op, d, s), result);
				else chk("result", model(op, d, s), result);
				chk("tags", op == 46 ? 64'hffff : 64'h0, {48'h0, tag_word});
				chk("stack top", 64'h0, {61'h0, stack_top});
				chk("direction", 1, {63'h0, res_ext});
			end
		for (op = 47; op < 64; op = op + 1) begin
			host.issue(op[5:0], 3'h1, 3'h2, 1, 1, 64'h0, 0, gd, gi);
			chk("refused", 64'h2, {62'h0, gi, gd});
		end
		d = {$random(seed), $random(seed)};
		host.issue(`PSALU_OP_MOVE_QUADWORD, 3'h5, 3'h0, 1, 0, d, 0, gd, gi);
		host.issue(`PSALU_OP_MOVE_QUADWORD, 3'h2, 3'h5, 0, 0, 64'h0, 0, gd, gi);
		chk("direction", 64'h0, {63'h0, res_ext});
		host.issue(`PSALU_OP_MOVE_QUADWORD, 3'h0, 3'h2, 0, 1, 64'h0, 0, gd, gi);
		chk("quad copy", d, result);
		host.issue(`PSALU_OP_MOVE_DOUBLEWORD, 3'h0, 3'h2, 0, 1, 64'h0, 0, gd, gi);
		chk("dword store", {32'h0, d[31:0]}, result);
		host.issue(`PSALU_OP_MOVE_DOUBLEWORD, 3'h3, 3'h0, 1, 0, ~d, 0, gd, gi);
		host.issue(`PSALU_OP_MOVE_QUADWORD, 3'h0, 3'h3, 0, 1, 64'h0, 0, gd, gi);
		chk("dword load", {32'h0, ~d[31:0]}, result);
		host.issue(`PSALU_OP_EMPTY_PACKED_STATE, 3'h0, 3'h0, 1, 1, 64'h0, 0, gd, gi);
		chk("empty tags", 64'hffff, {48'h0, tag_word});
		@(negedge sys_clk_i) resetn_i = 0;
		repeat (2) @(negedge sys_clk_i);
		resetn_i = 1;
		host.issue(`PSALU_OP_QUAD_BITWISE_XOR, 3'h5, 3'h0, 1, 1, 64'h0, 0, gd, gi);
		chk("xor after reset", d, result);
		test_done;
	end
endmodule

bind psalu_top psalu_top_asserts #(.FEATURE_PRESENT(FEATURE_PRESENT)) chk_i (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i), .opcode_i(opcode_i),
	.dst_ext_i(dst_ext_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
	.result_ext_o(result_ext_o), .result_o(result_o), .tag_word_o(tag_word_o),
	.stack_top_o(stack_top_o), .feature_word_o(feature_word_o));
